// ### hw/swtc_defs.vh
// constants of the sweep trigger control
`ifndef SWTC_DEFS_VH
`define SWTC_DEFS_VH
// ***********
// apb offsets
// ***********
`define SWTC_ADDR_EXT0 12'h000
`define SWTC_ADDR_EXT1 12'h004
`define SWTC_ADDR_EXT2 12'h008
`define SWTC_ADDR_EXT3 12'h00c
`define SWTC_ADDR_CMD 12'h010
`define SWTC_ADDR_STAT 12'h014
`define SWTC_ADDR_RAMP 12'h018
`define SWTC_ADDR_PEN 12'h01c
`define SWTC_ADDR_END 12'h020
`define SWTC_ADDR_HOLD 12'h024
// ***********
// field positions
// ***********
`define SWTC_E0_SINGLE 0
`define SWTC_E0_IRQEN 1
`define SWTC_E0_SRC_LO 2
`define SWTC_E0_HO_LO 5
`define SWTC_E1_RATE_LO 2
`define SWTC_E1_MODE_LO 2
`define SWTC_CMD_ABORT 0
`define SWTC_CMD_IGNORE 1
`define SWTC_CMD_GATEOFF 2
`define SWTC_CMD_ARM 3
// ***********
// reset values
// ***********
`define SWTC_RST_PEN 32'h0000_1ce0
`define SWTC_RST_END 32'h0000_1f40
`define SWTC_RST_HOLD 32'h0000_0040
// ***********
// codes
// ***********
`define SWTC_SRC_FREE 2'h0
`define SWTC_SRC_VIDEO 2'h1
`define SWTC_SRC_EXT 2'h2
`define SWTC_SRC_LINE 2'h3
`define SWTC_MODE_MANUAL 3'h7
`define SWTC_MODE_EXTSWP 3'h6
`endif

// ### hw/swtc_top.v
// sweep trigger control with apb register access
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "swtc_defs.vh"
module swtc_top #(
	parameter RAMP_W = 32,
	parameter RATE_BASE = 1
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire video_trig,
	input wire ext_trig,
	input wire line_trig,
	output reg sweep_active,
	output reg ramp_discharge,
	output reg pen_lift,
	output reg sweep_end_flag,
	output reg end_irq,
	output reg sweep_gate_off,
	output reg manual_sweep_line,
	output reg external_sweep_line,
	output reg [11:0] marker_code,
	output reg [11:0] horiz_out
);
// ***********
// registers
// ***********
reg [7:0] ext0;
reg [7:0] ext1;
reg [7:0] ext2;
reg [3:0] ext3;
reg [2:0] cmd_hold;
reg [RAMP_W-1:0] pen_thr;
reg [RAMP_W-1:0] end_thr;
reg [RAMP_W-1:0] hold_base;
reg armed;
wire wr = psel && penable && pwrite;
wire cancel = wr && paddr == `SWTC_ADDR_CMD && pwdata[`SWTC_CMD_ABORT];
wire rearm = wr && paddr == `SWTC_ADDR_CMD && pwdata[`SWTC_CMD_ARM];
assign pready = 1'b1;
assign pslverr = 1'b0;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ext0 <= 8'h00;
		ext1 <= 8'h00;
		ext2 <= 8'h00;
		ext3 <= 4'h0;
		cmd_hold <= 3'h0;
		pen_thr <= `SWTC_RST_PEN;
		end_thr <= `SWTC_RST_END;
		hold_base <= `SWTC_RST_HOLD;
	end else if (wr) begin
		case (paddr)
			`SWTC_ADDR_EXT0: ext0 <= pwdata[7:0];
			`SWTC_ADDR_EXT1: ext1 <= pwdata[7:0];
			`SWTC_ADDR_EXT2: ext2 <= pwdata[7:0];
			`SWTC_ADDR_EXT3: ext3 <= pwdata[3:0];
			`SWTC_ADDR_CMD: cmd_hold <= pwdata[2:0];
			`SWTC_ADDR_PEN: pen_thr <= pwdata[RAMP_W-1:0];
			`SWTC_ADDR_END: end_thr <= pwdata[RAMP_W-1:0];
			`SWTC_ADDR_HOLD: hold_base <= pwdata[RAMP_W-1:0];
			default: ;
		endcase
	end
end
// ***********
// read mux
// ***********
always @* begin
	case (paddr)
		`SWTC_ADDR_EXT0: prdata = {24'h000000, ext0};
		`SWTC_ADDR_EXT1: prdata = {24'h000000, ext1};
		`SWTC_ADDR_EXT2: prdata = {24'h000000, ext2};
		`SWTC_ADDR_EXT3: prdata = {28'h0000000, ext3};
		`SWTC_ADDR_CMD: prdata = {29'h00000000, cmd_hold};
		`SWTC_ADDR_STAT: prdata = {26'h0000000, armed, end_irq, sweep_end_flag, pen_lift, ramp_discharge, sweep_active};
		`SWTC_ADDR_PEN: prdata = pen_thr;
		`SWTC_ADDR_END: prdata = end_thr;
		`SWTC_ADDR_HOLD: prdata = hold_base;
		default: prdata = 32'h0000_0000;
	endcase
end
// ***********
// trigger sync and edge
// ***********
wire [2:0] rise;
swtc_sync_edge #(
	.IDLE(1'b0)
) i_sync_video (
	.pclk(pclk),
	.presetn(presetn),
	.async_in(video_trig),
	.rise(rise[0])
);
swtc_sync_edge #(
	.IDLE(1'b0)
) i_sync_ext (
	.pclk(pclk),
	.presetn(presetn),
	.async_in(ext_trig),
	.rise(rise[1])
);
swtc_sync_edge #(
	.IDLE(1'b0)
) i_sync_line (
	.pclk(pclk),
	.presetn(presetn),
	.async_in(line_trig),
	.rise(rise[2])
);
reg src_edge;
always @* begin
	case (ext0[`SWTC_E0_SRC_LO+1:`SWTC_E0_SRC_LO])
		`SWTC_SRC_FREE: src_edge = 1'b1;
		`SWTC_SRC_VIDEO: src_edge = rise[0];
		`SWTC_SRC_EXT: src_edge = rise[1];
		`SWTC_SRC_LINE: src_edge = rise[2];
		default: src_edge = 1'b0;
	endcase
end
// ***********
// rate and holdoff scaling
// ***********
reg [RAMP_W-1:0] rate_div;
always @* begin
	case (ext1[`SWTC_E1_RATE_LO+2:`SWTC_E1_RATE_LO])
		3'h0: rate_div = RATE_BASE * 2;
		3'h1: rate_div = RATE_BASE * 5;
		3'h2: rate_div = RATE_BASE * 10;
		3'h3: rate_div = RATE_BASE * 20;
		3'h4: rate_div = RATE_BASE * 50;
		3'h5: rate_div = RATE_BASE * 100;
		3'h6: rate_div = RATE_BASE * 200;
		default: rate_div = RATE_BASE * 500;
	endcase
	if (ext1[5]) begin
		rate_div = rate_div * 100;
	end
	if (ext1[6]) begin
		rate_div = rate_div * 100;
	end
end
reg [RAMP_W-1:0] hold_len;
always @* begin
	case (ext0[`SWTC_E0_HO_LO+1:`SWTC_E0_HO_LO])
		2'h0: hold_len = hold_base * rate_div;
		2'h1: hold_len = (hold_base * rate_div) << 2;
		default: hold_len = (hold_base * rate_div) << 4;
	endcase
end
wire [2:0] mode = ext1[`SWTC_E1_MODE_LO+2:`SWTC_E1_MODE_LO];
// ***********
// sweep state, ramp, holdoff
// ***********
reg [RAMP_W-1:0] ramp;
reg hold_done;
wire step_tick;
wire hold_tick;
wire qualified = hold_done && src_edge && armed && !cmd_hold[`SWTC_CMD_IGNORE];
wire reached_end = sweep_active && ramp >= end_thr;
swtc_step_div #(
	.CNT_W(RAMP_W)
) i_step_div (
	.pclk(pclk),
	.presetn(presetn),
	.clr(!sweep_active),
	.run(sweep_active),
	.limit(rate_div),
	.tick(step_tick)
);
swtc_step_div #(
	.CNT_W(RAMP_W)
) i_hold_div (
	.pclk(pclk),
	.presetn(presetn),
	.clr(sweep_active),
	.run(!hold_done),
	.limit(hold_len),
	.tick(hold_tick)
);
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sweep_active <= 1'b0;
		ramp <= {RAMP_W{1'b0}};
		hold_done <= 1'b0;
		armed <= 1'b1;
		sweep_end_flag <= 1'b0;
		end_irq <= 1'b0;
		pen_lift <= 1'b0;
	end else begin
		sweep_end_flag <= reached_end;
		end_irq <= reached_end && ext0[`SWTC_E0_IRQEN];
		if (sweep_active && (reached_end || cancel)) begin
			sweep_active <= 1'b0;
			hold_done <= 1'b0;
			ramp <= {RAMP_W{1'b0}};
			if (ext0[`SWTC_E0_SINGLE]) begin
				armed <= 1'b0;
			end
		end else if (sweep_active) begin
			if (step_tick) begin
				ramp <= ramp + 1'b1;
			end
		end else begin
			ramp <= {RAMP_W{1'b0}};
			if (hold_tick) begin
				hold_done <= 1'b1;
			end
			if (qualified || mode == `SWTC_MODE_MANUAL || mode == `SWTC_MODE_EXTSWP) begin
				sweep_active <= 1'b1;
			end
		end
		if (rearm) begin
			armed <= 1'b1;
		end else if (!ext0[`SWTC_E0_SINGLE]) begin
			armed <= 1'b1;
		end
		pen_lift <= sweep_active && ramp >= pen_thr;
	end
end
// ***********
// outputs
// ***********
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ramp_discharge <= 1'b1;
		sweep_gate_off <= 1'b0;
		manual_sweep_line <= 1'b0;
		external_sweep_line <= 1'b0;
		marker_code <= 12'h000;
		horiz_out <= 12'h000;
	end else begin
		ramp_discharge <= !sweep_active;
		sweep_gate_off <= cmd_hold[`SWTC_CMD_GATEOFF];
		manual_sweep_line <= mode == `SWTC_MODE_MANUAL;
		external_sweep_line <= mode == `SWTC_MODE_EXTSWP;
		marker_code <= {ext3, ext2};
		horiz_out <= sweep_active ? ramp[11:0] : {ext3, ext2};
	end
end
endmodule

// ***********
// two stage synchroniser with rising edge detect
// ***********
module swtc_sync_edge #(
	parameter IDLE = 1'b0
) (
	input wire pclk,
	input wire presetn,
	input wire async_in,
	output wire rise
);
reg stage_a;
reg stage_b;
reg stage_d;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		stage_a <= IDLE;
		stage_b <= IDLE;
		stage_d <= IDLE;
	end else begin
		stage_a <= async_in;
		stage_b <= stage_a;
		stage_d <= stage_b;
	end
end
// idle reset level avoids a false edge after reset
assign rise = stage_b & ~stage_d;
endmodule

// ***********
// cycle divider giving a one-cycle enable pulse
// ***********
module swtc_step_div #(
	parameter CNT_W = 32
) (
	input wire pclk,
	input wire presetn,
	input wire clr,
	input wire run,
	input wire [CNT_W-1:0] limit,
	output wire tick
);
reg [CNT_W-1:0] count;
reg [CNT_W-1:0] next_count;
assign tick = run && !clr && (count + 1'b1 >= limit);
always @* begin
	next_count = count;
	if (clr) begin
		next_count = {CNT_W{1'b0}};
	end else if (tick) begin
		next_count = {CNT_W{1'b0}};
	end else if (run) begin
		next_count = count + 1'b1;
	end
end
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		count <= {CNT_W{1'b0}};
	end else begin
		count <= next_count;
	end
end
endmodule

// ### dv/swtc_trig_src.sv
// trigger source model for the three trigger lines
`timescale 1ns/1ps
module swtc_trig_src (
	input wire pclk,
	input wire [2:0] fire,
	output reg video_trig = 1'h0,
	output reg ext_trig = 1'h0,
	output reg line_trig = 1'h0
);
// ******
// lines
// ******
// async to the clock, low when idle
always @(posedge pclk) begin
	{line_trig, ext_trig, video_trig} <= #3 fire;
end
endmodule

// ### dv/swtc_checker.sv
// assertions for the sweep trigger control
`timescale 1ns/1ps
module swtc_chk (
	input wire pclk,
	input wire presetn,
	input wire sweep_active,
	input wire ramp_discharge,
	input wire pen_lift,
	input wire sweep_end_flag,
	input wire end_irq,
	input wire manual_sweep_line,
	input wire external_sweep_line,
	input wire [11:0] marker_code,
	input wire [11:0] horiz_out
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
// ******
// checks
// ******
retrace_entry_a: assert property (sweep_end_flag |-> ##[0:2] !sweep_active)
	else $error("no retrace");
ramp_held_a: assert property (!sweep_active && !$past(sweep_active) |-> ramp_discharge)
	else $error("ramp not held");
irq_gate_a: assert property (end_irq |-> sweep_end_flag)
	else $error("stray irq");
pen_in_sweep_a: assert property ($rose(pen_lift) |-> sweep_active)
	else $error("pen outside sweep");
marker_out_a: assert property (ramp_discharge && $past(ramp_discharge) && $stable(marker_code) |-> horiz_out == marker_code)
	else $error("marker not out");
end_pulse_a: assert property (sweep_end_flag |=> !sweep_end_flag)
	else $error("end flag long");
manual_run_a: assert property (manual_sweep_line |-> ##[0:4] sweep_active)
	else $error("manual not run");
holdoff_wait_a: assert property ($fell(sweep_active) && !manual_sweep_line && !external_sweep_line |=> !sweep_active)
	else $error("no holdoff");
end_cov: cover property (sweep_end_flag);
irq_cov: cover property (end_irq);
manual_cov: cover property (manual_sweep_line && sweep_active);
endmodule
bind swtc_top swtc_chk i_swtc_chk (.*);

// ### dv/tb.sv
// testbench of the sweep trigger control
`timescale 1ns/1ps
`include "swtc_defs.vh"
module tb;
reg pclk = 1'h0;
reg presetn = 1'h0;
reg psel = 1'h0;
reg penable = 1'h0;
reg pwrite = 1'h0;
reg [11:0] paddr = 12'h0;
reg [31:0] pwdata = 32'h0;
reg [2:0] fire = 3'h0;
reg [31:0] v;
wire [31:0] prdata;
wire [11:0] marker_code, horiz_out;
wire pready, pslverr, video_trig, ext_trig, line_trig, sweep_active, ramp_discharge, pen_lift;
wire sweep_end_flag, end_irq, sweep_gate_off, manual_sweep_line, external_sweep_line;
integer fails = 0;
integer checks_done = 0;
integer cyc = 0;
integer n1, n2, s;
always #10 pclk = ~pclk;
swtc_top i_swtc_top (.*);
swtc_trig_src i_swtc_trig_src (.*);
// ******
// tasks
// ******
task chk(input string w, input [31:0] seen, input [31:0] exp);
	checks_done = checks_done + 1;
	if (seen !== exp) begin
		fails = fails + 1;
		$display("ERROR %s expected %h seen %h", w, exp, seen);
	end
endtask
task print_verdict;
	$display("fails %0d checks %0d", fails, checks_done);
	if (fails == 0 && checks_done > 0) begin
		$display("Simulation passed");
	end else begin
		$display("Simulation failed");
	end
	$finish;
endtask
task xfer(input w, input [11:0] a, input [31:0] d);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'h1;
	@(posedge pclk);
	while (pready !== 1'h1) @(posedge pclk);
	v = prdata;
	psel <= 1'h0;
	penable <= 1'h0;
	@(posedge pclk);
endtask
task pulse(input [2:0] m);
	fire <= m;
	repeat (2) @(posedge pclk);
	fire <= 3'h0;
	repeat (8) @(posedge pclk);
endtask
task meas(input [31:0] ie, output integer n);
	@(posedge pclk iff sweep_end_flag);
	chk("irq", end_irq, ie);
	chk("pen", pen_lift, 1);
	@(posedge pclk iff sweep_active !== 1'h1);
	for (n = 0; sweep_active !== 1'h1; n = n + 1) @(posedge pclk);
endtask
always @(posedge pclk) begin
	cyc <= cyc + 1;
	if (cyc == 5000) begin
		fails = fails + 1;
		print_verdict;
	end
end
// ******
// tests
// ******
initial begin
	repeat (4) @(posedge pclk);
	presetn <= 1'h1;
	@(posedge pclk);
	xfer(0, `SWTC_ADDR_END, 0);
	chk("end thr", v, `SWTC_RST_END);
	xfer(0, `SWTC_ADDR_RAMP, 0);
	chk("unmapped", v, 32'h0);
	xfer(1, `SWTC_ADDR_END, 32'h8);
	xfer(1, `SWTC_ADDR_PEN, 32'h7);
	xfer(1, `SWTC_ADDR_HOLD, 32'h1);
	meas(0, n1);
	xfer(1, `SWTC_ADDR_EXT1, 32'h4);
	meas(0, n2);
	chk("rate hold", n2 > n1, 1);
	xfer(1, `SWTC_ADDR_EXT1, 32'h0);
	xfer(1, `SWTC_ADDR_EXT0, 32'h22);
	meas(1, n2);
	chk("long hold", n2 > n1, 1);
	xfer(1, `SWTC_ADDR_EXT2, 32'hab);
	xfer(1, `SWTC_ADDR_EXT3, 32'h5);
	@(posedge pclk);
	chk("marker", marker_code, 32'h5ab);
	xfer(1, `SWTC_ADDR_EXT0, 32'h0);
	@(posedge pclk iff sweep_active);
	xfer(1, `SWTC_ADDR_CMD, 32'h1);
	chk("cancel", sweep_active, 0);
	xfer(1, `SWTC_ADDR_EXT0, 32'h1);
	@(posedge pclk iff sweep_end_flag);
	for (s = 1; s < 4; s = s + 1) begin
		xfer(1, `SWTC_ADDR_EXT0, 32'h1 | (s << 2));
		xfer(1, `SWTC_ADDR_CMD, 32'h8);
		pulse(3'h7 ^ (3'h1 << (s - 1)));
		chk("other src", sweep_active, 0);
		pulse(3'h1 << (s - 1));
		chk("src", sweep_active, 1);
		@(posedge pclk iff sweep_end_flag);
		pulse(3'h1 << (s - 1));
		chk("single", sweep_active, 0);
	end
	xfer(1, `SWTC_ADDR_CMD, 32'he);
	pulse(3'h4);
	chk("ignore", sweep_active, 0);
	chk("gate off", sweep_gate_off, 1);
	xfer(1, `SWTC_ADDR_CMD, 32'h0);
	xfer(1, `SWTC_ADDR_EXT1, 32'h1c);
	@(posedge pclk);
	chk("manual", manual_sweep_line, 1);
	repeat (4) @(posedge pclk);
	chk("manual run", sweep_active, 1);
	xfer(1, `SWTC_ADDR_EXT1, 32'h18);
	@(posedge pclk);
	chk("ext sweep", external_sweep_line, 1);
	print_verdict;
end
endmodule
